// file: src/deca_io_map.sv
// Register image and pin multiplexer of the dual electronic cam
`timescale 1ns/100ps
module deca_io_map (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] field_in_pins,
    output logic [7:0] field_out_pins,
    input wire logic [6:0] cfg_merge,
    input wire logic [1:0] cfg_mpol,
    input wire logic [1:0] cfg_mphs,
    input wire logic [1:0] cfg_int_clk,
    input wire logic [7:0] cfg_out_pol,
    input wire logic [1:0] cfg_thresh,
    input wire logic [1:0] cfg_filter,
    input wire logic [1:0] cfg_psc_a,
    input wire logic [1:0] cfg_psc_b,
    output logic [1:0] in_thresh_sel,
    output logic [1:0] in_filter_sel
);
    import deca_pkg::*;

    logic [7:0] in_s1_ff;
    logic [7:0] in_s2_ff;
    logic [6:0] gpo_ff;
    logic mask_ff;
    logic [6:0] mrg_ff;
    logic [7:0] chan_ff;
    logic [7:0] pol_ff;
    logic [7:0] cond_ff;
    deca_word_t setp_ff [16];
    deca_word_t cpr_ff [2];
    logic [31:0] prdata_ff;
    logic [7:0] out_ff;
    logic [1:0] thr_ff;
    logic [1:0] flt_ff;
    logic [4:0] tick_cnt_ff;
    logic tick_ff;
    logic [31:0] rd_val;
    logic hit;
    logic wr_en;
    logic setp_hit;
    logic [6:0] eff_mrg;
    logic [7:0] eff_pol;
    logic [1:0] eff_thr;
    logic [1:0] eff_flt;
    logic [1:0] eff_psc [2];
    logic [1:0] eff_mpol;
    logic [1:0] eff_mphs;
    logic [1:0] eff_clk;
    deca_word_t cnt [2];
    logic [3:0] lobe [2];
    logic [7:0] cam_sig;
    logic [7:0] acc;
    logic [7:0] nxt_out;

    function automatic deca_word_t wr16(deca_word_t old, logic [31:0] d, logic [3:0] s);
        wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : wr16

    // Pins come from the field, so two flip-flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_s1_ff <= 8'h00;
            in_s2_ff <= 8'h00;
        end else begin
            in_s1_ff <= field_in_pins;
            in_s2_ff <= in_s1_ff;
        end
    end

    // Address decode; unaligned or unknown offsets answer with an error
    assign setp_hit = (paddr[11:6] == SETP_PAGE) && (paddr[1:0] == 2'b00);
    always_comb begin
        rd_val = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            A_IN: rd_val = {24'h00_0000, in_s2_ff};
            A_GPO: rd_val = {25'h0, gpo_ff};
            A_OVR: rd_val = {24'h00_0000, mrg_ff, mask_ff};
            A_CHAN: rd_val = {24'h00_0000, chan_ff};
            A_POL: rd_val = {24'h00_0000, pol_ff};
            A_COND: rd_val = {24'h00_0000, cond_ff};
            A_OPT: rd_val = {16'h0000, OPTION_NUM};
            A_CNTA: rd_val = {16'h0000, cnt[0]};
            A_CNTB: rd_val = {16'h0000, cnt[1]};
            A_CPRA: rd_val = {16'h0000, cpr_ff[0]};
            A_CPRB: rd_val = {16'h0000, cpr_ff[1]};
            default: begin
                if (setp_hit) begin
                    rd_val = {16'h0000, setp_ff[paddr[5:2]]};
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    end

    // Zero wait states; read data caught in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_ff;
    assign wr_en = psel & penable & pwrite & hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= rd_val;
        end
    end

    // Latched general outputs and override control bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpo_ff <= RST_GPO;
            mask_ff <= 1'b0;
            mrg_ff <= RST_GPO;
            chan_ff <= RST_CTRL;
            pol_ff <= RST_CTRL;
            cond_ff <= RST_CTRL;
        end else if (wr_en && pstrb[0]) begin
            case (paddr)
                A_GPO: gpo_ff <= pwdata[6:0];
                A_OVR: begin
                    mask_ff <= pwdata[OVR_MASK];
                    mrg_ff <= pwdata[OVR_MRG +: 7];
                end
                A_CHAN: chan_ff <= pwdata[7:0];
                A_POL: pol_ff <= pwdata[7:0];
                A_COND: cond_ff <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Set-point words, stored by index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                setp_ff[i] <= RST_WORD;
            end
        end else if (wr_en && setp_hit) begin
            setp_ff[paddr[5:2]] <= wr16(setp_ff[paddr[5:2]], pwdata, pstrb);
        end
    end

    // Counts-per-revolution words; zero means the full 16-bit turn
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpr_ff[0] <= RST_WORD;
            cpr_ff[1] <= RST_WORD;
        end else if (wr_en && paddr == A_CPRA) begin
            cpr_ff[0] <= wr16(cpr_ff[0], pwdata, pstrb);
        end else if (wr_en && paddr == A_CPRB) begin
            cpr_ff[1] <= wr16(cpr_ff[1], pwdata, pstrb);
        end
    end

    // 1 MHz tick divided from pclk for time-based counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff <= 5'h00;
            tick_ff <= 1'b0;
        end else begin
            tick_cnt_ff <= (tick_cnt_ff == TICK_LAST) ? 5'h00 : tick_cnt_ff + 5'h01;
            tick_ff <= (tick_cnt_ff == TICK_LAST);
        end
    end

    // Override mux: register bits other than the counter reset bits only count while the mask is set
    assign eff_mrg = mask_ff ? mrg_ff : cfg_merge;
    assign eff_pol = mask_ff ? pol_ff : cfg_out_pol;
    assign eff_thr = mask_ff ? cond_ff[COND_THR +: 2] : cfg_thresh;
    assign eff_flt = mask_ff ? cond_ff[COND_FLT +: 2] : cfg_filter;
    assign eff_psc[0] = mask_ff ? cond_ff[COND_PSA +: 2] : cfg_psc_a;
    assign eff_psc[1] = mask_ff ? cond_ff[COND_PSB +: 2] : cfg_psc_b;

    // Both channels share one structure; counter reset bits act at once
    generate
        for (genvar c = 0; c < 2; c++) begin : g_ch
            localparam int B = c * CH_STRIDE;
            deca_word_t lo [4];
            deca_word_t hi [4];
            logic ch_rstn;
            assign eff_mpol[c] = mask_ff ? chan_ff[B + CH_MPOL] : cfg_mpol[c];
            assign eff_mphs[c] = mask_ff ? chan_ff[B + CH_MPHS] : cfg_mphs[c];
            assign eff_clk[c] = mask_ff ? chan_ff[B + CH_CLK] : cfg_int_clk[c];
            // Combined reset: the presetn input ANDed with the inverted reset bit flop of the channel
            assign ch_rstn = presetn & ~chan_ff[B + CH_RST];
            for (genvar k = 0; k < 4; k++) begin : g_sp
                assign lo[k] = setp_ff[c * 8 + k * 2];
                assign hi[k] = setp_ff[c * 8 + k * 2 + 1];
            end
            deca_cam_channel u_chan (
                .pclk(pclk),
                .cnt_rstn(ch_rstn),
                .enc_a(in_s2_ff[B + PIN_A]),
                .enc_b(in_s2_ff[B + PIN_B]),
                .marker(in_s2_ff[B + PIN_M]),
                .marker_dis(in_s2_ff[B + PIN_MD]),
                .mk_pol(eff_mpol[c]),
                .mk_phs(eff_mphs[c]),
                .int_clk_sel(eff_clk[c]),
                .psc_sel(eff_psc[c]),
                .tick(tick_ff),
                .cpr(cpr_ff[c]),
                .lo_setp(lo),
                .hi_setp(hi),
                .count(cnt[c]),
                .lobe_act(lobe[c])
            );
        end
    endgenerate

    // Cam chain: a merged signal is ORed into the next pin's signal
    assign cam_sig = {lobe[1], lobe[0]} ^ eff_pol;
    assign acc[0] = cam_sig[0];
    generate
        for (genvar i = 1; i < 8; i++) begin : g_acc
            assign acc[i] = cam_sig[i] | (eff_mrg[i - 1] & acc[i - 1]);
        end
        for (genvar i = 0; i < 7; i++) begin : g_pin
            assign nxt_out[i] = eff_mrg[i] ? gpo_ff[i] : acc[i];
        end
    endgenerate
    // Last pin can never be freed, so at least one cam pin remains
    assign nxt_out[7] = acc[7];

    // Pin drivers and conditioning selects come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= 8'h00;
            thr_ff <= 2'h0;
            flt_ff <= 2'h0;
        end else begin
            out_ff <= nxt_out;
            thr_ff <= eff_thr;
            flt_ff <= eff_flt;
        end
    end
    assign field_out_pins = out_ff;
    assign in_thresh_sel = thr_ff;
    assign in_filter_sel = flt_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Reset qualifier: selects still show reset values at the first edge after release
    a_stored_config: assert property (presetn && !mask_ff |=> in_filter_sel == $past(cfg_filter)
        && in_thresh_sel == $past(cfg_thresh))
        else $error("stored configuration not used while mask clear");
    a_merge_masked: assert property (!mask_ff && !cfg_merge[0]
        |=> field_out_pins[0] == $past(cam_sig[0]))
        else $error("merge register took effect without mask");
    a_cnt_a_clear: assert property (chan_ff[CH_RST] |-> cnt[0] == RST_WORD)
        else $error("counter A not held clear by its reset bit");
    a_cnt_b_clear: assert property (chan_ff[CH_STRIDE + CH_RST] |-> cnt[1] == RST_WORD)
        else $error("counter B not held clear by its reset bit");
    a_pol_invert: assert property (mask_ff && !eff_mrg[6]
        |=> field_out_pins[7] == ($past(lobe[1][3]) ^ $past(pol_ff[7])))
        else $error("output polarity not applied under override");
    a_thresh_ovr: assert property (mask_ff |=> in_thresh_sel == $past(cond_ff[COND_THR +: 2]))
        else $error("threshold override not applied");
    a_filter_ovr: assert property (mask_ff |=> in_filter_sel == $past(cond_ff[COND_FLT +: 2]))
        else $error("filter override not applied");
    a_option_read: assert property (psel && !penable && !pwrite && paddr == A_OPT
        |=> prdata == {16'h0000, OPTION_NUM})
        else $error("option number read wrong");
    a_input_read: assert property (psel && !penable && !pwrite && paddr == A_IN
        |=> prdata == {24'h00_0000, $past(in_s2_ff)})
        else $error("input word not live pin state");
    a_gpo_pin: assert property (eff_mrg[0] |=> field_out_pins[0] == $past(gpo_ff[0]))
        else $error("freed pin does not show latched output");
    a_cam_pin: assert property (!eff_mrg[0] |=> field_out_pins[0] == $past(cam_sig[0]))
        else $error("unmerged pin does not show its cam signal");

    // Merge chain and freed pins
    a_chain_or: assert property (eff_mrg[0] && !eff_mrg[1]
        |=> field_out_pins[1] == ($past(cam_sig[1]) | $past(cam_sig[0])))
        else $error("merged cam signal not combined into next pin");
    a_gpo_pin6: assert property (eff_mrg[6] |=> field_out_pins[6] == $past(gpo_ff[6]))
        else $error("freed last general pin does not show latched output");
    a_pin7_merged: assert property (eff_mrg[6]
        |=> field_out_pins[7] == ($past(cam_sig[7]) | $past(acc[6])))
        else $error("last pin lost its merged cam signals");

    // Register reads and writes
    a_input_sync: assert property ($past(presetn, 2) |-> in_s2_ff == $past(field_in_pins, 2))
        else $error("input word not two edges behind the pins");
    a_cnt_a_read: assert property (psel && !penable && !pwrite && paddr == A_CNTA
        |=> prdata == {16'h0000, $past(cnt[0])})
        else $error("counter A read wrong");
    a_cnt_b_read: assert property (psel && !penable && !pwrite && paddr == A_CNTB
        |=> prdata == {16'h0000, $past(cnt[1])})
        else $error("counter B read wrong");
    a_ovr_write: assert property (psel && penable && pwrite && pstrb[0] && paddr == A_OVR
        |=> mask_ff == $past(pwdata[OVR_MASK]))
        else $error("override mask write lost");

    // Time base: one-cycle pulse, so the counter sees one event per microsecond
    a_tick_rate: assert property (tick_ff |=> !tick_ff)
        else $error("internal tick wider than one cycle");

    c_override_on: cover property ($rose(mask_ff));
    c_gpo_used: cover property (eff_mrg[0] && gpo_ff[0] ##1 field_out_pins[0]);
    c_bad_addr: cover property (pslverr);
    c_all_merged: cover property (eff_mrg == 7'h7f);
endmodule : deca_io_map

// file: src/deca_pkg.sv
// Shared constants for the dual electronic cam register block
package deca_pkg;
    // Clock and internal time base
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned INT_CLK_HZ = 1_000_000;
    localparam logic [4:0] TICK_LAST = 5'(CLK_HZ / INT_CLK_HZ - 1);
    // Option number shown to software
    localparam logic [15:0] OPTION_NUM = 16'h0004;
    // Register byte offsets
    localparam logic [11:0] A_IN = 12'h000;
    localparam logic [11:0] A_GPO = 12'h004;
    localparam logic [11:0] A_OVR = 12'h008;
    localparam logic [11:0] A_CHAN = 12'h00c;
    localparam logic [11:0] A_POL = 12'h010;
    localparam logic [11:0] A_COND = 12'h014;
    localparam logic [11:0] A_OPT = 12'h018;
    localparam logic [11:0] A_CNTA = 12'h01c;
    localparam logic [11:0] A_CNTB = 12'h020;
    localparam logic [5:0] SETP_PAGE = 6'h01;
    localparam logic [11:0] A_CPRA = 12'h080;
    localparam logic [11:0] A_CPRB = 12'h084;
    // Field positions
    localparam int OVR_MASK = 0;
    localparam int OVR_MRG = 1;
    localparam int CH_MPOL = 0;
    localparam int CH_MPHS = 1;
    localparam int CH_CLK = 2;
    localparam int CH_RST = 3;
    localparam int CH_STRIDE = 4;
    localparam int COND_THR = 0;
    localparam int COND_FLT = 2;
    localparam int COND_PSA = 4;
    localparam int COND_PSB = 6;
    // Input pin positions per channel
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_M = 2;
    localparam int PIN_MD = 3;
    // Values after reset
    localparam logic [6:0] RST_GPO = 7'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    typedef logic [15:0] deca_word_t;
endpackage : deca_pkg

// file: src/deca_cam_channel.sv
// One cam channel: counter, prescaler, marker and four lobes
`timescale 1ns/100ps
module deca_cam_channel (
    input wire logic pclk,
    input wire logic cnt_rstn,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic marker,
    input wire logic marker_dis,
    input wire logic mk_pol,
    input wire logic mk_phs,
    input wire logic int_clk_sel,
    input wire logic [1:0] psc_sel,
    input wire logic tick,
    input wire deca_pkg::deca_word_t cpr,
    input wire deca_pkg::deca_word_t lo_setp [4],
    input wire deca_pkg::deca_word_t hi_setp [4],
    output deca_pkg::deca_word_t count,
    output logic [3:0] lobe_act
);
    import deca_pkg::*;
    logic a_d_ff;
    logic [2:0] psc_ff;
    deca_word_t cnt_ff;
    logic src_ev, cnt_ev, mk_q;
    logic [2:0] psc_last;
    deca_word_t max_cnt;

    // Count source: 1 MHz tick or rising edge of phase A
    assign src_ev = int_clk_sel ? tick : (enc_a & ~a_d_ff);
    assign psc_last = 3'((4'd1 << psc_sel) - 4'd1);
    assign cnt_ev = src_ev & (psc_ff == psc_last);
    assign max_cnt = cpr - 16'h0001; // Zero gives the full 16-bit range
    // Marker qualified by polarity, phase of B and its disable input
    assign mk_q = (marker ^ mk_pol) & (enc_b ^ mk_phs) & ~marker_dis & ~int_clk_sel;
    assign count = cnt_ff;

    // Edge history and prescaler, cleared with the counter
    always_ff @(posedge pclk or negedge cnt_rstn) begin
        if (!cnt_rstn) begin
            a_d_ff <= 1'b0;
            psc_ff <= 3'h0;
        end else begin
            a_d_ff <= enc_a;
            if (src_ev) begin
                psc_ff <= (psc_ff >= psc_last) ? 3'h0 : psc_ff + 3'h1;
            end
        end
    end

    // Position counter; >= recovers at once if the wrap word is lowered
    always_ff @(posedge pclk or negedge cnt_rstn) begin
        if (!cnt_rstn) begin
            cnt_ff <= RST_WORD;
        end else if (cnt_ev) begin
            cnt_ff <= (mk_q || cnt_ff >= max_cnt) ? RST_WORD : cnt_ff + 16'h0001;
        end
    end

    // Lobe windows, high clamped to maximum, dead if low beyond it
    generate
        for (genvar k = 0; k < 4; k++) begin : g_lobe
            assign lobe_act[k] = (lo_setp[k] <= max_cnt) && (cnt_ff >= lo_setp[k])
                && ((cnt_ff < hi_setp[k]) || (max_cnt < hi_setp[k]));
        end
    endgenerate

    a_cnt_wrap: assert property (@(posedge pclk) disable iff (!cnt_rstn)
        (cnt_ev && cnt_ff == max_cnt) |=> cnt_ff == RST_WORD)
        else $error("counter did not wrap at the counts-per-revolution word");
    c_cnt_wrap: cover property (@(posedge pclk) disable iff (!cnt_rstn)
        cnt_ev && cnt_ff == max_cnt && cpr == 16'h0008);
endmodule : deca_cam_channel

// file: verification/deca_enc_model.sv
// Quadrature encoder model feeding both cam channels
`timescale 1ns/100ps
module deca_enc_model (
    input wire logic pclk,
    input wire logic step_req,
    input wire logic [3:0] gap,
    input wire logic [1:0] mk,
    input wire logic [1:0] mk_dis,
    output logic step_done,
    output logic [7:0] pins
);
    logic ph_a;
    logic ph_b;
    // One shaft drives both channels; marker lines are static levels
    assign pins = {mk_dis[1], mk[1], ph_b, ph_a, mk_dis[0], mk[0], ph_b, ph_a};
    // One quadrature cycle per request, A leading; lines stand still between steps
    initial begin
        ph_a = 1'b0;
        ph_b = 1'b0;
        step_done = 1'b0;
        forever begin
            @(posedge pclk);
            step_done <= 1'b0;
            if (step_req && !step_done) begin
                repeat (gap) @(posedge pclk);
                ph_a <= 1'b1;
                repeat (gap) @(posedge pclk);
                ph_b <= 1'b1;
                repeat (gap) @(posedge pclk);
                ph_a <= 1'b0;
                repeat (gap) @(posedge pclk);
                ph_b <= 1'b0;
                step_done <= 1'b1;
            end
        end
    end
endmodule : deca_enc_model

// file: verification/deca_io_map_bench.sv
// Self-checking bench for the cam register block
`timescale 1ns/100ps
module deca_io_map_bench;
    import deca_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, step_req, step_done;
    logic [11:0] paddr, ra;
    logic [31:0] pwdata, prdata, last_rd, r, rm;
    logic [3:0] pstrb, gap;
    logic [7:0] in_pins, out_pins, cfg_pol, e;
    logic [6:0] cfg_merge;
    logic [1:0] cfg_thr, cfg_flt, thr_sel, flt_sel, mk, mk_dis, cfg_clk;
    logic [32:0] exp_q[$], care_q[$], e_v, c_v;
    string name_q[$];
    int n_errors = 0;
    int compares = 0;
    int lo_t[4] = '{2, 3, 9, 0};
    int hi_t[4] = '{5, 20, 12, 1};
    logic [11:0] reg_a[7] = '{A_GPO, A_OVR, A_CHAN, A_POL, A_COND, A_CPRA, A_CPRB};
    logic [31:0] reg_m[7] = '{32'h7f, 32'hff, 32'hff, 32'hff, 32'hff, 32'hffff, 32'hffff};

    deca_io_map i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .field_in_pins(in_pins), .field_out_pins(out_pins), .cfg_merge(cfg_merge), .cfg_mpol(2'b00),
        .cfg_mphs(2'b00), .cfg_int_clk(cfg_clk), .cfg_out_pol(cfg_pol), .cfg_thresh(cfg_thr),
        .cfg_filter(cfg_flt), .cfg_psc_a(2'b00), .cfg_psc_b(2'b00), .in_thresh_sel(thr_sel),
        .in_filter_sel(flt_sel));
    deca_enc_model i_enc (.pclk(pclk), .step_req(step_req), .gap(gap), .mk(mk), .mk_dis(mk_dis),
        .step_done(step_done), .pins(in_pins));

    // 20 MHz clock
    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] x);
        compares++;
        if (seen !== x) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, x, seen);
        end
    endtask : check

    // Watcher: each finished transfer takes the oldest note; error flag rides in bit 32
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            e_v = exp_q.pop_front();
            c_v = care_q.pop_front();
            last_rd = prdata;
            check(name_q.pop_front(), {pslverr, pwrite ? 32'h0 : prdata} & c_v, e_v & c_v);
        end
    end

    // Request held until pready is seen; released one edge before the next setup
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input string nm, input logic [11:0] a, input logic [32:0] x, input logic [32:0] c = '1);
        exp_q.push_back(x);
        care_q.push_back(c);
        name_q.push_back(nm);
        apb(1'b0, a, 32'h0, 4'h0);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf, input logic er = 0);
        exp_q.push_back({er, 32'h0});
        care_q.push_back('1);
        name_q.push_back("write response");
        apb(1'b1, a, d, s);
    endtask : wr

    task automatic settle();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    task automatic pin_chk(input logic [7:0] x);
        settle();
        check("cam pins", {25'h0, out_pins}, {25'h0, x});
        @(posedge pclk);
    endtask : pin_chk

    // Encoder steps at a random pace; waits bounded by the model handshake
    task automatic step(input int n);
        for (int k = 0; k < n; k++) begin
            step_req <= 1'b1;
            gap <= 4'($urandom_range(1, 6));
            for (int t = 0; t < 200 && step_done !== 1'b1; t++) @(posedge pclk);
            step_req <= 1'b0;
            @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
    endtask : step

    // High beyond the last count is clamped and then inclusive
    function automatic logic lobe(input int c, input int lo, input int hi, input int cpr);
        if (lo > cpr - 1) return 1'b0;
        if (hi > cpr - 1) return c >= lo;
        return c >= lo && c < hi;
    endfunction : lobe

    function automatic logic [7:0] exp_pins(input int ca, input int cb, input logic [7:0] pol);
        for (int i = 0; i < 4; i++) begin
            exp_pins[i] = lobe(ca, lo_t[i], hi_t[i], 8) ^ pol[i];
            exp_pins[i + 4] = lobe(cb, lo_t[i], hi_t[i], 16) ^ pol[i + 4];
        end
    endfunction : exp_pins

    task automatic results();
        if (n_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // Hang guard, more than ten times the cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        results();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h31ec));
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb, step_req, gap, cfg_merge, cfg_pol, cfg_clk} = '0;
        {cfg_thr, cfg_flt, mk, mk_dis} = 8'($urandom);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("option number", A_OPT, {17'h0, OPTION_NUM});
        wr(A_OPT, 32'hffff);
        rd("option number", A_OPT, {17'h0, OPTION_NUM});
        wr(12'h0f0, 32'h1, 4'hf, 1'b1);
        rd("unmapped read", 12'h0fc, {1'b1, 32'h0});
        rd("unaligned read", 12'h006, {1'b1, 32'h0});
        wr(A_IN, 32'hff);
        rd("input pins", A_IN, {25'h0, in_pins});
        mk <= 2'b00;
        mk_dis <= 2'b11;
        for (int i = 0; i < 23; i++) begin
            ra = (i < 7) ? reg_a[i] : 12'h040 + 12'(4 * (i - 7));
            rm = (i < 7) ? reg_m[i] : 32'hffff;
            r = $urandom;
            rd("reset value", ra, 33'h0);
            wr(ra, r);
            rd("read back", ra, {1'b0, r & rm});
            wr(ra, 32'h0);
        end
        wr(A_GPO, 32'h7f, 4'he);
        rd("byte strobe", A_GPO, 33'h0);
        wr(A_CPRA, 32'h1234, 4'h2);
        rd("lane strobe", A_CPRA, 33'h1200);
        wr(A_CPRA, 32'h8);
        wr(A_CPRB, 32'h10);
        wr(A_CHAN, 32'h88);
        wr(A_CHAN, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(12'h040 + 12'(4 * i), 32'((i % 2) ? hi_t[i / 2] : lo_t[i / 2]));
            wr(12'h060 + 12'(4 * i), 32'((i % 2) ? hi_t[i / 2] : lo_t[i / 2]));
        end
        settle();
        check("threshold", {31'h0, thr_sel}, {31'h0, cfg_thr});
        check("filter", {31'h0, flt_sel}, {31'h0, cfg_flt});
        @(posedge pclk);
        r = $urandom;
        wr(A_COND, r & 32'hf);
        wr(A_OVR, 32'h1);
        settle();
        check("threshold", {31'h0, thr_sel}, {31'h0, r[1:0]});
        check("filter", {31'h0, flt_sel}, {31'h0, r[3:2]});
        @(posedge pclk);
        wr(A_OVR, 32'h0);
        wr(A_COND, 32'h0);
        // Walk through one wrap of channel A and most of channel B
        for (int s = 0; s <= 10; s++) begin
            pin_chk(exp_pins(s % 8, s, 8'h00));
            rd("counter a", A_CNTA, 33'(s % 8));
            rd("counter b", A_CNTB, 33'(s));
            step(1);
        end
        cfg_pol <= 8'h01;
        pin_chk(exp_pins(3, 11, 8'h01));
        wr(A_POL, 32'h2);
        pin_chk(exp_pins(3, 11, 8'h01));
        wr(A_OVR, 32'h1);
        pin_chk(exp_pins(3, 11, 8'h02));
        wr(A_OVR, 32'h0);
        cfg_merge <= 7'h01;
        wr(A_GPO, 32'h1);
        e = exp_pins(3, 11, 8'h01);
        pin_chk({e[7:2], e[1] | e[0], 1'b1});
        wr(A_OVR, 32'hff);
        e = exp_pins(3, 11, 8'h02);
        wr(A_GPO, 32'h2a);
        pin_chk({|e, 7'h2a});
        wr(A_OVR, 32'h1);
        pin_chk(e);
        wr(A_CHAN, 32'h8);
        rd("counter a", A_CNTA, 33'h0);
        step(1);
        rd("counter a", A_CNTA, 33'h0);
        rd("counter b", A_CNTB, 33'hc);
        wr(A_CHAN, 32'h80);
        rd("counter b", A_CNTB, 33'h0);
        wr(A_CHAN, 32'h0);
        wr(A_COND, 32'h10);
        step(4);
        rd("prescaled a", A_CNTA, 33'h2);
        rd("counter b", A_CNTB, 33'h4);
        wr(A_COND, 32'h0);
        // Marker on A enabled: inverted polarity and phase make it fire on every rising A edge
        mk_dis <= 2'b10;
        wr(A_CHAN, 32'h3);
        step(2);
        rd("marker zero", A_CNTA, 33'h0);
        wr(A_CHAN, 32'h1);
        step(1);
        rd("marker phase", A_CNTA, 33'h1);
        wr(A_CHAN, 32'hc);
        wr(A_CHAN, 32'h4);
        repeat (100) @(posedge pclk);
        rd("tick count", A_CNTA, 33'h0, 33'h0);
        check("tick count", {32'h0, last_rd >= 4 && last_rd <= 6}, 33'h1);
        // Mask cleared: the stored clock select alone must run counter A from the tick
        cfg_clk <= 2'b01;
        wr(A_OVR, 32'h0);
        wr(A_CHAN, 32'h8);
        wr(A_CHAN, 32'h0);
        repeat (100) @(posedge pclk);
        rd("stored clock", A_CNTA, 33'h0, 33'h0);
        check("stored clock", {32'h0, last_rd >= 4 && last_rd <= 6}, 33'h1);
        results();
    end
endmodule : deca_io_map_bench
